/* File: redriver_cfg_pkg.sv */
// Constants, field layouts and carrier types for the lane configuration register bank.
// Assumes a single 125 MHz clock domain and a byte-wide register access port.
package redriver_cfg_pkg;

	// Register space
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int NUM_LANES = 4;
	localparam logic [DATA_W-1:0] REG_SPACE_BYTES = 8'h20;

	// Byte offsets
	localparam logic [ADDR_W-1:0] BYTE_COUNT_OFS = 5'h02;
	localparam logic [ADDR_W-1:0] RX2_LANE_TUNING_OFS = 5'h05;
	localparam logic [ADDR_W-1:0] TX2_LANE_TUNING_OFS = 5'h06;
	localparam logic [ADDR_W-1:0] TX1_LANE_TUNING_OFS = 5'h07;
	localparam logic [ADDR_W-1:0] RX1_LANE_TUNING_OFS = 5'h08;
	localparam logic [ADDR_W-1:0] RESERVED_BYTE_NINE_OFS = 5'h09;
	localparam logic [ADDR_W-1:0] PAIR_TWO_FEATURES_OFS = 5'h0a;
	localparam logic [ADDR_W-1:0] PAIR_ONE_FEATURES_OFS = 5'h0b;
	localparam logic [ADDR_W-1:0] THRESHOLD_AND_ENABLES_OFS = 5'h0c;
	localparam logic [ADDR_W-1:0] FIRST_RESERVED_TAIL_OFS = 5'h0d;

	// Lane array index for each lane byte: index = offset - first lane offset
	localparam logic [1:0] RX2_IDX = 2'h0;
	localparam logic [1:0] TX2_IDX = 2'h1;
	localparam logic [1:0] TX1_IDX = 2'h2;
	localparam logic [1:0] RX1_IDX = 2'h3;

	// Reset values
	localparam logic [DATA_W-1:0] LANE_TUNING_RST = 8'h07;
	localparam logic [DATA_W-1:0] FEATURES_RST = 8'hfc;
	localparam logic [DATA_W-1:0] THRESHOLD_AND_ENABLES_RST = 8'h58;
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

	// Detector threshold codes
	localparam logic [1:0] THRESH_50_MVPPD = 2'h0;
	localparam logic [1:0] THRESH_65_MVPPD = 2'h1;
	localparam logic [1:0] THRESH_80_MVPPD = 2'h2;
	localparam logic [1:0] THRESH_95_MVPPD = 2'h3;

	// Cycles after reset release before the synchronised pins are trusted
	localparam logic [1:0] PIN_SETTLE_CYCLES = 2'h3;

	// One lane byte: equalizer 7:4, flat gain 3:2, amplitude 1:0
	typedef struct packed {
		logic [3:0] eq_code;
		logic [1:0] flat_gain_code;
		logic [1:0] output_amplitude_code;
	} lane_tuning_t;

	// Byte twelve layout
	typedef struct packed {
		logic [1:0] detector_threshold;
		logic [2:0] rsvd_hi;
		logic hotplug_pin_enable_n;
		logic sideband_mux_enable_n;
		logic rsvd_lo;
	} thresh_enables_t;

	// One register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

endpackage : redriver_cfg_pkg

/* File: redriver_lane_config_regs.sv */
// Byte-wide lane configuration register bank of a four-lane linear redriver.
// Assumes a serial bus front end that presents one-cycle read and write strobes
// on sys_clk, and that strap and lane pins are asynchronous board levels.
`timescale 1ns/1ps

module redriver_lane_config_regs
	import redriver_cfg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire reg_req_t reg_req,
	output logic [DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic serial_cfg_enable,
	input wire lane_tuning_t [NUM_LANES-1:0] lane_pin_tuning,
	input wire logic hotplug_input,
	output lane_tuning_t second_receive_lane,
	output lane_tuning_t second_transmit_lane,
	output lane_tuning_t first_transmit_lane,
	output lane_tuning_t first_receive_lane,
	output logic [DATA_W-1:0] lane_pair_two,
	output logic [DATA_W-1:0] lane_pair_one,
	output logic [1:0] detector_threshold,
	output logic hotplug_detect,
	output logic sideband_mux_enable,
	output logic serial_cfg_writable
);

	localparam int SYNC_W = 2 + NUM_LANES * DATA_W;

	// Lane byte decode, shared by the write path and the checks
	function automatic logic is_lane_addr(input logic [ADDR_W-1:0] a);
		is_lane_addr = (a >= RX2_LANE_TUNING_OFS) && (a <= RX1_LANE_TUNING_OFS);
	endfunction : is_lane_addr

	function automatic logic [1:0] lane_idx(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] d;
		d = a - RX2_LANE_TUNING_OFS;
		lane_idx = d[1:0];
	endfunction : lane_idx

	logic [SYNC_W-1:0] pin_s1_ff;
	logic [SYNC_W-1:0] pin_s2_ff;
	logic [SYNC_W-1:0] pin_s3_ff;
	logic [SYNC_W-1:0] pin_ff;
	logic [SYNC_W-1:0] nxt_pin;
	logic [1:0] settle_cnt_ff;
	logic loaded_ff;
	logic load_pulse;
	logic strap_ff;
	logic hotplug_ff;
	lane_tuning_t [NUM_LANES-1:0] pin_lanes;
	lane_tuning_t [NUM_LANES-1:0] lane_ff;
	logic [DATA_W-1:0] pair_two_ff;
	logic [DATA_W-1:0] pair_one_ff;
	thresh_enables_t thresh_ff;
	logic lane_wr_ok;
	logic [DATA_W-1:0] nxt_rdata;

	// Three-stage pin synchroniser; stage one feeds only stage two
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			pin_s3_ff <= '0;
		end else begin
			pin_s1_ff <= {serial_cfg_enable, hotplug_input, lane_pin_tuning};
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
		end
	end

	// A bit changes only once stages two and three agree
	always_comb begin
		for (int i = 0; i < SYNC_W; i++) begin
			nxt_pin[i] = (pin_s2_ff[i] == pin_s3_ff[i]) ? pin_s3_ff[i] : pin_ff[i];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_ff <= '0;
		end else begin
			pin_ff <= nxt_pin;
		end
	end

	assign strap_ff = pin_ff[SYNC_W-1];
	assign hotplug_ff = pin_ff[SYNC_W-2];
	// Load from the next filtered value: pin_ff itself only fills at the load edge
	assign pin_lanes = nxt_pin[NUM_LANES*DATA_W-1:0];

	// Wait for the synchroniser to fill before trusting the lane pins
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			settle_cnt_ff <= '0;
			loaded_ff <= 1'b0;
		end else if (!loaded_ff) begin
			if (settle_cnt_ff == PIN_SETTLE_CYCLES) begin
				loaded_ff <= 1'b1;
			end else begin
				settle_cnt_ff <= settle_cnt_ff + 2'h1;
			end
		end
	end

	assign load_pulse = !loaded_ff && (settle_cnt_ff == PIN_SETTLE_CYCLES);
	// Writes before the pin load would be overwritten, so they are dropped until it
	assign lane_wr_ok = loaded_ff && strap_ff;

	// Lane bytes: pin values once after reset, then host writes if allowed
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NUM_LANES; i++) begin
				lane_ff[i] <= LANE_TUNING_RST;
			end
		end else if (load_pulse) begin
			lane_ff <= pin_lanes;
		end else if (reg_req.wr && is_lane_addr(reg_req.addr) && lane_wr_ok) begin
			lane_ff[lane_idx(reg_req.addr)] <= reg_req.wdata;
		end
	end

	// Per-pair feature bytes
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pair_two_ff <= FEATURES_RST;
			pair_one_ff <= FEATURES_RST;
		end else if (reg_req.wr) begin
			if (reg_req.addr == PAIR_TWO_FEATURES_OFS) begin
				pair_two_ff <= reg_req.wdata;
			end
			if (reg_req.addr == PAIR_ONE_FEATURES_OFS) begin
				pair_one_ff <= reg_req.wdata;
			end
		end
	end

	// Threshold and enables; reserved bits are plain storage
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			thresh_ff <= THRESHOLD_AND_ENABLES_RST;
		end else if (reg_req.wr && reg_req.addr == THRESHOLD_AND_ENABLES_OFS) begin
			thresh_ff <= reg_req.wdata;
		end
	end

	// Read mux; unmapped and reserved bytes read zero, writes to them vanish
	always_comb begin
		nxt_rdata = READ_ZERO;
		if (is_lane_addr(reg_req.addr)) begin
			nxt_rdata = lane_ff[lane_idx(reg_req.addr)];
		end else begin
			case (reg_req.addr)
				BYTE_COUNT_OFS: nxt_rdata = REG_SPACE_BYTES;
				PAIR_TWO_FEATURES_OFS: nxt_rdata = pair_two_ff;
				PAIR_ONE_FEATURES_OFS: nxt_rdata = pair_one_ff;
				THRESHOLD_AND_ENABLES_OFS: nxt_rdata = thresh_ff;
				default: nxt_rdata = READ_ZERO;
			endcase
		end
	end

	// Read data registered, valid one cycle after the strobe
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= READ_ZERO;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_req.rd;
			if (reg_req.rd) begin
				reg_rdata <= nxt_rdata;
			end
		end
	end

	// Control outputs, all straight from flip-flops
	assign second_receive_lane = lane_ff[RX2_IDX];
	assign second_transmit_lane = lane_ff[TX2_IDX];
	assign first_transmit_lane = lane_ff[TX1_IDX];
	assign first_receive_lane = lane_ff[RX1_IDX];
	assign lane_pair_two = pair_two_ff;
	assign lane_pair_one = pair_one_ff;
	assign detector_threshold = thresh_ff.detector_threshold;
	assign serial_cfg_writable = strap_ff;

	// Pin ignored while the active-low enable is set
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			hotplug_detect <= 1'b0;
			sideband_mux_enable <= 1'b0;
		end else begin
			hotplug_detect <= hotplug_ff && !thresh_ff.hotplug_pin_enable_n;
			sideband_mux_enable <= !thresh_ff.sideband_mux_enable_n;
		end
	end

	// Steps of a lane write under each strap level
	sequence s_lane_write_open;
		reg_req.wr && is_lane_addr(reg_req.addr) && loaded_ff && strap_ff && !load_pulse;
	endsequence

	sequence s_lane_write_locked;
		reg_req.wr && is_lane_addr(reg_req.addr) && !strap_ff && !load_pulse;
	endsequence

	a_lane_locked_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_lane_write_locked |=> lane_ff == $past(lane_ff))
		else $error("lane byte changed while strap low");

	a_lane_open_store: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_lane_write_open
		|=> lane_ff[lane_idx($past(reg_req.addr))] == $past(reg_req.wdata))
		else $error("lane byte did not take written value");

	a_rx2_byte_map: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_lane_write_open and (reg_req.addr == RX2_LANE_TUNING_OFS)
		|=> second_receive_lane == $past(reg_req.wdata))
		else $error("byte 5 did not reach second receive lane");

	a_tx2_byte_map: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_lane_write_open and (reg_req.addr == TX2_LANE_TUNING_OFS)
		|=> second_transmit_lane == $past(reg_req.wdata))
		else $error("byte 6 did not reach second transmit lane");

	a_tx1_byte_map: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_lane_write_open and (reg_req.addr == TX1_LANE_TUNING_OFS)
		|=> first_transmit_lane == $past(reg_req.wdata))
		else $error("byte 7 did not reach first transmit lane");

	a_rx1_byte_map: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_lane_write_open and (reg_req.addr == RX1_LANE_TUNING_OFS)
		|=> first_receive_lane == $past(reg_req.wdata))
		else $error("byte 8 did not reach first receive lane");

	a_pin_load_once: assert property (@(posedge sys_clk) disable iff (!arst_n)
		load_pulse |=> lane_ff == $past(pin_lanes) ##1 !load_pulse [*4])
		else $error("lane pins not loaded once at power-up");

	a_rsvd_nine_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
		reg_req.rd && reg_req.addr == RESERVED_BYTE_NINE_OFS |=> reg_rdata == READ_ZERO)
		else $error("reserved byte nine read nonzero");

	a_pair_two_store: assert property (@(posedge sys_clk) disable iff (!arst_n)
		reg_req.wr && reg_req.addr == PAIR_TWO_FEATURES_OFS
		|=> lane_pair_two == $past(reg_req.wdata) && lane_pair_one == $past(lane_pair_one))
		else $error("pair two feature write wrong");

	a_pair_one_store: assert property (@(posedge sys_clk) disable iff (!arst_n)
		reg_req.wr && reg_req.addr == PAIR_ONE_FEATURES_OFS
		|=> lane_pair_one == $past(reg_req.wdata) && lane_pair_two == $past(lane_pair_two))
		else $error("pair one feature write wrong");

	a_thresh_select: assert property (@(posedge sys_clk) disable iff (!arst_n)
		reg_req.wr && reg_req.addr == THRESHOLD_AND_ENABLES_OFS
		|=> detector_threshold == $past(reg_req.wdata[7:6]))
		else $error("detector threshold not taken from bits 7:6");

	a_hotplug_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
		thresh_ff.hotplug_pin_enable_n [*2] |-> !hotplug_detect)
		else $error("hot-plug pin seen while disabled");

	a_sideband_en: assert property (@(posedge sys_clk) disable iff (!arst_n)
		reg_req.wr && reg_req.addr == THRESHOLD_AND_ENABLES_OFS
		|=> ##1 sideband_mux_enable == !$past(reg_req.wdata[1], 2))
		else $error("sideband mux enable not active low");

	a_rsvd_tail_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
		reg_req.rd && reg_req.addr >= FIRST_RESERVED_TAIL_OFS |=> reg_rdata == READ_ZERO)
		else $error("reserved tail byte read nonzero");

	a_byte_count: assert property (@(posedge sys_clk) disable iff (!arst_n)
		reg_req.rd && reg_req.addr == BYTE_COUNT_OFS |=> reg_rvalid && reg_rdata == REG_SPACE_BYTES)
		else $error("byte count not reported as 32");

	// Writes to reserved bytes and early lane writes store nothing
	sequence s_rsvd_write;
		reg_req.wr && !load_pulse
			&& (reg_req.addr == RESERVED_BYTE_NINE_OFS
			|| reg_req.addr >= FIRST_RESERVED_TAIL_OFS);
	endsequence

	sequence s_lane_write_early;
		reg_req.wr && is_lane_addr(reg_req.addr) && !loaded_ff && !load_pulse;
	endsequence

	// No register may move on a reserved write, whatever the data
	a_rsvd_write_inert: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_rsvd_write |=> lane_ff == $past(lane_ff) && pair_two_ff == $past(pair_two_ff)
			&& pair_one_ff == $past(pair_one_ff) && thresh_ff == $past(thresh_ff))
		else $error("reserved byte write changed a register");

	// A write ahead of the pin load would be lost anyway, so it must not land
	a_lane_wait_load: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_lane_write_early |=> lane_ff == $past(lane_ff))
		else $error("lane byte written before pin load");

	// Reserved bits of byte twelve are plain read-write storage
	a_rsvd_bits_rw: assert property (@(posedge sys_clk) disable iff (!arst_n)
		reg_req.wr && reg_req.addr == THRESHOLD_AND_ENABLES_OFS
		|=> thresh_ff.rsvd_hi == $past(reg_req.wdata[5:3])
			&& thresh_ff.rsvd_lo == $past(reg_req.wdata[0]))
		else $error("reserved bits of byte twelve not stored");

	a_thresh_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!(reg_req.wr && reg_req.addr == THRESHOLD_AND_ENABLES_OFS)
		|=> thresh_ff == $past(thresh_ff))
		else $error("byte twelve changed without a write");

	// With the gate open the output follows the filtered pin one cycle later
	a_hotplug_pass: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!thresh_ff.hotplug_pin_enable_n |=> hotplug_detect == $past(hotplug_ff))
		else $error("hot-plug pin not passed while enabled");

	// A strap glitch seen by one stage only must not flip the lock
	a_strap_filter: assert property (@(posedge sys_clk) disable iff (!arst_n)
		pin_s2_ff[SYNC_W-1] != pin_s3_ff[SYNC_W-1] |=> strap_ff == $past(strap_ff))
		else $error("strap changed before synchroniser stages agreed");

	// Read answer is a one-cycle pulse and the data holds between reads
	a_read_answer: assert property (@(posedge sys_clk) disable iff (!arst_n)
		reg_req.rd |=> reg_rvalid)
		else $error("read strobe not answered next cycle");

	a_read_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!reg_req.rd |=> !reg_rvalid && reg_rdata == $past(reg_rdata))
		else $error("read port moved without a read strobe");

endmodule : redriver_lane_config_regs

/* File: cfg_host_model.sv */
// Host side model of the register access port: single-byte reads and writes.
// Assumes the register bank takes strobes on the rising edge of sys_clk.
`timescale 1ns/1ps
module cfg_host_model
	import redriver_cfg_pkg::*;
(
	input wire logic sys_clk,
	output reg_req_t req,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic rvalid
);
	// Bus idle from time zero
	initial req = '0;

	// Write strobe stands one cycle, dropped at the edge that takes it
	task automatic write(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
		@(posedge sys_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(posedge sys_clk);
		req <= '0;
	endtask : write

	// Read strobe, then a bounded wait so a lost answer cannot hang the host
	task automatic read(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data,
		output bit ok);
		int k;
		ok = 1'b0;
		data = '0;
		@(posedge sys_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: '0};
		@(posedge sys_clk);
		req <= '0;
		// Answer stands one cycle only, so look right after each edge
		for (k = 0; k < 4 && !ok; k++) begin
			#1;
			if (rvalid === 1'b1) begin
				ok = 1'b1;
				data = rdata;
			end else begin
				@(posedge sys_clk);
			end
		end
	endtask : read
endmodule : cfg_host_model

/* File: redriver_lane_config_regs_test.sv */
// Self-checking bench for the lane configuration register bank.
// Assumes cfg_host_model drives the register port; pins are driven here.
`timescale 1ns/1ps
module redriver_lane_config_regs_test
	import redriver_cfg_pkg::*;
;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic serial_cfg_enable = 1'b1;
	logic hotplug_input = 1'b1;
	lane_tuning_t [NUM_LANES-1:0] lane_pin_tuning = {8'h4d, 8'h3c, 8'h2b, 8'h1a};
	reg_req_t reg_req;
	logic [7:0] reg_rdata, lane_pair_two, lane_pair_one, rd_data;
	logic reg_rvalid, hotplug_detect, sideband_mux_enable, serial_cfg_writable;
	lane_tuning_t second_receive_lane, second_transmit_lane, first_transmit_lane;
	lane_tuning_t first_receive_lane;
	logic [1:0] detector_threshold;
	bit ok;
	int i;
	int n_mismatch = 0;
	int checked = 0;
	// Lane bytes 5..8 side by side, byte 5 lowest
	wire [31:0] lanes = {first_receive_lane, first_transmit_lane, second_transmit_lane,
		second_receive_lane};

	always #4 sys_clk = ~sys_clk;

	cfg_host_model host (.sys_clk, .req(reg_req), .rdata(reg_rdata), .rvalid(reg_rvalid));

	redriver_lane_config_regs uut (.sys_clk, .arst_n, .reg_req, .reg_rdata, .reg_rvalid,
		.serial_cfg_enable, .lane_pin_tuning, .hotplug_input, .second_receive_lane,
		.second_transmit_lane, .first_transmit_lane, .first_receive_lane, .lane_pair_two,
		.lane_pair_one, .detector_threshold, .hotplug_detect, .sideband_mux_enable,
		.serial_cfg_writable);

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	// Read and compare; a lost answer ends the run
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
		host.read(a, rd_data, ok);
		if (!ok) begin
			n_mismatch++;
			results();
		end else begin
			check($sformatf("byte %0d", a), rd_data, exp);
		end
	endtask : rd_chk

	// Byte twelve write, reserved bits kept at power-up values; then let pins path settle
	task automatic b12(input logic [1:0] th, input logic hp, input logic sb);
		host.write(THRESHOLD_AND_ENABLES_OFS, {th, 3'h3, hp, sb, 1'h0});
		repeat (3) @(posedge sys_clk);
		#1;
	endtask : b12

	// Power-up view of the whole space
	function automatic logic [7:0] exp_byte(input int a);
		case (a)
			2: return 8'h20;
			5, 6, 7, 8: return lane_pin_tuning[a-5];
			10, 11: return 8'hfc;
			12: return 8'h58;
			default: return 8'h00;
		endcase
	endfunction : exp_byte

	// Watchdog so nothing hangs
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_mismatch++;
		results();
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		check("rx2 in reset", second_receive_lane, 8'h07);
		check("pair two in reset", lane_pair_two, 8'hfc);
		arst_n <= 1'b1;
		// Lane write ahead of the pin load must be dropped
		host.write(RX2_LANE_TUNING_OFS, 8'h00);
		#1;
		check("early write lost", second_receive_lane, 8'h07);
		repeat (6) @(posedge sys_clk);
		#1;
		for (i = 0; i < 4; i++) check("pin load", lanes[i*8 +: 8], lane_pin_tuning[i]);
		check("writable", serial_cfg_writable, 1'b1);
		check("sideband on", sideband_mux_enable, 1'b1);
		for (i = 0; i < 32; i++) rd_chk(i[4:0], exp_byte(i));
		// Strap high: every lane byte takes a write, one idle cycle between strobes
		for (i = 0; i < 4; i++) host.write(RX2_LANE_TUNING_OFS + i[4:0], 8'h96 + 8'(i));
		#1;
		for (i = 0; i < 4; i++) begin
			check("lane out", lanes[i*8 +: 8], 8'h96 + 8'(i));
			rd_chk(RX2_LANE_TUNING_OFS + i[4:0], 8'h96 + 8'(i));
		end
		check("eq field", first_receive_lane.eq_code, 8'h09);
		check("gain field", first_receive_lane.flat_gain_code, 8'h02);
		check("amp field", first_receive_lane.output_amplitude_code, 8'h01);
		host.write(PAIR_TWO_FEATURES_OFS, 8'h5a);
		host.write(PAIR_ONE_FEATURES_OFS, 8'ha5);
		#1;
		check("pair two", lane_pair_two, 8'h5a);
		check("pair one", lane_pair_one, 8'ha5);
		// Reserved bytes written with their power-up value must touch nothing
		host.write(RESERVED_BYTE_NINE_OFS, 8'h00);
		host.write(5'h1f, 8'h00);
		rd_chk(RESERVED_BYTE_NINE_OFS, 8'h00);
		rd_chk(5'h1f, 8'h00);
		rd_chk(PAIR_ONE_FEATURES_OFS, 8'ha5);
		// Every threshold code, hot-plug and sideband left enabled
		for (i = 0; i < 4; i++) begin
			b12(i[1:0], 1'b0, 1'b0);
			check("threshold", detector_threshold, i[1:0]);
			check("hotplug on", hotplug_detect, 1'b1);
			rd_chk(THRESHOLD_AND_ENABLES_OFS, {i[1:0], 6'h18});
		end
		b12(2'h1, 1'b1, 1'b1);
		check("hotplug masked", hotplug_detect, 1'b0);
		check("sideband off", sideband_mux_enable, 1'b0);
		b12(2'h1, 1'b0, 1'b0);
		check("sideband back", sideband_mux_enable, 1'b1);
		// Pin low must reach the output once enabled
		@(posedge sys_clk);
		hotplug_input <= 1'b0;
		repeat (7) @(posedge sys_clk);
		#1;
		check("hotplug follows pin", hotplug_detect, 1'b0);
		// Strap low: lane writes accepted but dropped
		@(posedge sys_clk);
		serial_cfg_enable <= 1'b0;
		repeat (8) @(posedge sys_clk);
		#1;
		check("not writable", serial_cfg_writable, 1'b0);
		host.write(RX2_LANE_TUNING_OFS, 8'h00);
		repeat (2) @(posedge sys_clk);
		#1;
		check("lane kept", second_receive_lane, 8'h96);
		rd_chk(RX2_LANE_TUNING_OFS, 8'h96);
		results();
	end
endmodule : redriver_lane_config_regs_test
